// ### hw/frt_pkg.sv
// ****************************************************************
// Shared constants for the free-run timer and input capture.
// ****************************************************************
package frt_pkg;
    localparam int unsigned CNT_W      = 16;
    localparam int unsigned NUM_CH     = 4;
    localparam int unsigned ADDR_W     = 8;

    // ************************************************************
    // Register byte offsets.
    // ************************************************************
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_COUNT   = 8'h04;
    localparam logic [7:0] OFS_CAP01   = 8'h08;
    localparam logic [7:0] OFS_CAP23   = 8'h0c;
    localparam logic [7:0] OFS_VAL0    = 8'h10;
    localparam logic [7:0] OFS_VAL1    = 8'h14;
    localparam logic [7:0] OFS_VAL2    = 8'h18;
    localparam logic [7:0] OFS_VAL3    = 8'h1c;
    localparam logic [7:0] OFS_STATUS  = 8'h20;
    localparam logic [7:0] OFS_MASK    = 8'h24;

    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int unsigned CTRL_EN_BIT  = 0;
    localparam int unsigned CTRL_SEL_LSB = 1;
    localparam int unsigned CTRL_CLR_BIT = 3;
    localparam int unsigned ST_OVF_BIT   = 0;
    localparam int unsigned ST_CAP_LSB   = 1;
    localparam int unsigned PAIR_IE_LSB  = 4;
    localparam int unsigned PAIR_FL_LSB  = 6;

    // ************************************************************
    // Reset values and limits.
    // ************************************************************
    localparam logic [3:0]  CTRL_RST   = 4'h0;
    localparam logic [15:0] CNT_RST    = 16'h0000;
    localparam logic [15:0] CNT_MAX    = 16'hffff;
    localparam logic [4:0]  IRQ_RST    = 5'h00;
    localparam logic [2:0]  DIV_RST    = 3'h0;

    typedef enum logic [1:0] {
        EDGE_NONE, EDGE_RISE, EDGE_FALL, EDGE_BOTH
    } frt_edge_type;

    typedef enum logic [1:0] {
        SEL_DIV2, SEL_DIV4, SEL_DIV8, SEL_EXT
    } frt_clk_sel_type;
endpackage

// ### hw/frt_tick.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Count tick generator with four selectable sources.
// ****************************************************************
module frt_tick
    import frt_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset,
    // Source selection and external pin
    input  wire logic [1:0] sel,
    input  wire logic       ext_clk_pin,
    // Tick out
    output logic            tick
);
    logic [2:0] div_ff;
    logic [2:0] ext_ff;
    logic       tick_ff;
    logic       nxt_tick;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            div_ff <= DIV_RST;
        end else begin
            div_ff <= div_ff + 3'h1;
        end
    end

    // The pin passes two flops before the edge detector looks at it.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ext_ff <= 3'h0;
        end else begin
            ext_ff <= {ext_ff[1:0], ext_clk_pin};
        end
    end

    always_comb begin
        unique case (frt_clk_sel_type'(sel))
            SEL_DIV2: nxt_tick = (div_ff[0] == 1'b1);
            SEL_DIV4: nxt_tick = (div_ff[1:0] == 2'h3);
            SEL_DIV8: nxt_tick = (div_ff == 3'h7);
            SEL_EXT:  nxt_tick = ext_ff[1] & ~ext_ff[2];
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;
endmodule // frt_tick
`default_nettype wire

// ### hw/frt_capture_ch.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// One input capture channel.
// ****************************************************************
module frt_capture_ch
    import frt_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              reset,
    // Pin and setup
    input  wire logic              cap_pin,
    input  wire logic [1:0]        edge_sel,
    input  wire logic [CNT_W-1:0]  timebase,
    // Results
    output logic                   cap_event,
    output logic [CNT_W-1:0]       cap_value
);
    logic [2:0]       pin_ff;
    logic             rise;
    logic             fall;
    logic             hit;
    logic             event_ff;
    logic [CNT_W-1:0] value_ff;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pin_ff <= 3'h0;
        end else begin
            pin_ff <= {pin_ff[1:0], cap_pin};
        end
    end

    assign rise = pin_ff[1] & ~pin_ff[2];
    assign fall = ~pin_ff[1] & pin_ff[2];

    always_comb begin
        unique case (frt_edge_type'(edge_sel))
            EDGE_NONE: hit = 1'b0;
            EDGE_RISE: hit = rise;
            EDGE_FALL: hit = fall;
            EDGE_BOTH: hit = rise | fall;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            event_ff <= 1'b0;
            value_ff <= CNT_RST;
        end else begin
            event_ff <= hit;
            if (hit) begin
                value_ff <= timebase;
            end
        end
    end

    assign cap_event = event_ff;
    assign cap_value = value_ff;
endmodule // frt_capture_ch
`default_nettype wire

// ### hw/frt_timer.sv
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// (R1) Sixteen-bit counter steps once per enabled tick.
// (R2) Counter value feeds compare and capture.
// (R3) Tick source chosen from four options.
// (R4) Wrap past maximum raises overflow request.
// (R5) Optional clear on compare register zero match.
// (R6) Selected edge latches counter into channel.
// (R7) Valid capture edge can raise interrupt.
// (R8) Each channel has own pin, own detector.
// (R9) Four channels: edge select, enable, flag.
module frt_timer
    import frt_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              reset,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Pins
    input  wire logic              ext_clk_pin,
    input  wire logic [NUM_CH-1:0] capture_pin,
    // Output compare side
    input  wire logic [CNT_W-1:0]  compare_clear0,
    output logic [CNT_W-1:0]       timebase_value,
    // Interrupt
    output logic                   irq
);
    // ************************************************************
    // Declarations.
    // ************************************************************
    logic [3:0]             ctrl_ff;
    logic [CNT_W-1:0]       count_ff;
    logic [CNT_W-1:0]       nxt_count;
    logic [7:0]             pair_sel_ff;
    logic [4:0]             mask_ff;
    logic [4:0]             status_ff;
    logic [4:0]             set_bits;
    logic [4:0]             clr_bits;
    logic                   irq_ff;
    logic                   pready_ff;
    logic                   pslverr_ff;
    logic [31:0]            prdata_ff;
    logic [31:0]            nxt_prdata;
    logic                   nxt_err;
    logic                   access;
    logic                   done;
    logic                   wr;
    logic                   tick;
    logic                   run;
    logic                   match_clr;
    logic                   wrap;
    logic [NUM_CH-1:0]      cap_event;
    logic [CNT_W-1:0]       cap_value [NUM_CH];
    logic [7:0]             pair01;
    logic [7:0]             pair23;

    // ************************************************************
    // APB slave.
    // ************************************************************
    // One wait state keeps read data on a flop at the cost of speed.
    assign access = psel & penable;
    assign done   = access & pready_ff;
    assign wr     = done & pwrite;

    assign pair01 = {status_ff[ST_CAP_LSB+1], status_ff[ST_CAP_LSB],
                     mask_ff[2], mask_ff[1], pair_sel_ff[3:0]};
    assign pair23 = {status_ff[ST_CAP_LSB+3], status_ff[ST_CAP_LSB+2],
                     mask_ff[4], mask_ff[3], pair_sel_ff[7:4]};

    always_comb begin
        nxt_prdata = 32'h0000_0000;
        nxt_err    = 1'b0;
        if (paddr[1:0] != 2'h0) begin
            nxt_err = 1'b1;
        end else begin
            unique case (paddr)
                OFS_CTRL:   nxt_prdata = {28'h000_0000, ctrl_ff};
                OFS_COUNT:  nxt_prdata = {16'h0000, count_ff};
                OFS_CAP01:  nxt_prdata = {24'h00_0000, pair01};
                OFS_CAP23:  nxt_prdata = {24'h00_0000, pair23};
                OFS_VAL0:   nxt_prdata = {16'h0000, cap_value[0]};
                OFS_VAL1:   nxt_prdata = {16'h0000, cap_value[1]};
                OFS_VAL2:   nxt_prdata = {16'h0000, cap_value[2]};
                OFS_VAL3:   nxt_prdata = {16'h0000, cap_value[3]};
                OFS_STATUS: nxt_prdata = {27'h000_0000, status_ff};
                OFS_MASK:   nxt_prdata = {27'h000_0000, mask_ff};
                default:    nxt_err    = 1'b1;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= access & ~pready_ff;
            pslverr_ff <= access & ~pready_ff & nxt_err;
            if (access & ~pready_ff & ~pwrite) begin
                prdata_ff <= nxt_prdata;
            end
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;

    // ************************************************************
    // Control and mask registers.
    // ************************************************************
    // (R1) (R3) (R5) Control register write.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl_ff <= CTRL_RST;
        end else if (wr && paddr == OFS_CTRL) begin
            ctrl_ff <= pwdata[3:0];
        end
    end

    // (R9) Edge selects and interrupt enables.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pair_sel_ff <= 8'h00;
            mask_ff     <= IRQ_RST;
        end else if (wr && paddr == OFS_CAP01) begin
            pair_sel_ff[3:0] <= pwdata[3:0];
            mask_ff[2:1]     <= pwdata[PAIR_IE_LSB+1:PAIR_IE_LSB];
        end else if (wr && paddr == OFS_CAP23) begin
            pair_sel_ff[7:4] <= pwdata[3:0];
            mask_ff[4:3]     <= pwdata[PAIR_IE_LSB+1:PAIR_IE_LSB];
        end else if (wr && paddr == OFS_MASK) begin
            mask_ff <= pwdata[4:0];
        end
    end

    // ************************************************************
    // Timebase counter.
    // ************************************************************
    // (R3) Tick source selection.
    frt_tick u_tick (
        .core_clk    (core_clk),
        .reset       (reset),
        .sel         (ctrl_ff[CTRL_SEL_LSB+1:CTRL_SEL_LSB]),
        .ext_clk_pin (ext_clk_pin),
        .tick        (tick)
    );

    assign run       = tick & ctrl_ff[CTRL_EN_BIT];
    assign match_clr = ctrl_ff[CTRL_CLR_BIT] & (count_ff == compare_clear0);
    assign wrap      = run & ~match_clr & (count_ff == CNT_MAX);

    // (R1) (R5) Step or clear on match.
    always_comb begin
        nxt_count = count_ff;
        if (run) begin
            if (match_clr) begin
                nxt_count = CNT_RST;
            end else begin
                nxt_count = count_ff + 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            count_ff <= CNT_RST;
        end else begin
            count_ff <= nxt_count;
        end
    end

    // (R2) Common time reference.
    assign timebase_value = count_ff;

    // ************************************************************
    // Capture channels.
    // ************************************************************
    // (R8) One pin and detector per channel.
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        frt_capture_ch u_ch (
            .core_clk  (core_clk),
            .reset     (reset),
            .cap_pin   (capture_pin[i]),
            .edge_sel  (pair_sel_ff[2*i+1:2*i]),
            .timebase  (count_ff),
            .cap_event (cap_event[i]),
            .cap_value (cap_value[i])
        );
    end

    // ************************************************************
    // Interrupt status.
    // ************************************************************
    assign set_bits = {cap_event, wrap};

    always_comb begin
        clr_bits = 5'h00;
        if (wr && paddr == OFS_STATUS) begin
            clr_bits = pwdata[4:0];
        end else if (wr && paddr == OFS_CAP01) begin
            clr_bits[2:1] = pwdata[PAIR_FL_LSB+1:PAIR_FL_LSB];
        end else if (wr && paddr == OFS_CAP23) begin
            clr_bits[4:3] = pwdata[PAIR_FL_LSB+1:PAIR_FL_LSB];
        end
    end

    // (R4) (R7) Sticky flags; a new event beats a clear.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            status_ff <= IRQ_RST;
        end else begin
            status_ff <= (status_ff & ~clr_bits) | set_bits;
        end
    end

    // (R4) (R7) Masked interrupt level.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(status_ff & mask_ff);
        end
    end

    assign irq = irq_ff;

    // ************************************************************
    // Assertions.
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // (R1) Counter steps by one.
    cnt_step_a: assert property ( // (R1)
        run && !match_clr && count_ff != CNT_MAX
        |=> count_ff == $past(count_ff) + 16'h0001)
        else $error("counter did not step by one");

    // (R1) Counter holds without tick.
    cnt_hold_a: assert property ( // (R1)
        !run |=> $stable(count_ff))
        else $error("counter moved without a tick");

    // (R2) Reference moves only after a run tick.
    tb_ref_a: assert property ( // (R2)
        timebase_value == count_ff && $changed(count_ff)
        |-> $past(run))
        else $error("timebase moved without a tick");

    // (R3) Divide by two alternates.
    div2_tick_a: assert property ( // (R3)
        ctrl_ff[2:1] == 2'h0 && $stable(ctrl_ff) && tick |=> !tick)
        else $error("divide by two ticked twice in a row");

    // (R4) Overflow wraps and flags.
    ovf_flag_a: assert property ( // (R4)
        wrap |=> count_ff == CNT_RST && status_ff[ST_OVF_BIT]
        ##1 (irq || !$past(mask_ff[ST_OVF_BIT])))
        else $error("overflow did not wrap and flag");

    // (R5) Match clears counter.
    match_clr_a: assert property ( // (R5)
        run && match_clr |=> count_ff == CNT_RST
        && (!status_ff[ST_OVF_BIT] || $past(status_ff[ST_OVF_BIT])))
        else $error("compare match did not clear counter");

    // (R6) Capture latches timebase.
    cap_latch_a: assert property ( // (R6)
        cap_event[0] |-> cap_value[0] == $past(count_ff, 1))
        else $error("captured value differs from timebase");

    // (R7) Capture raises interrupt.
    cap_irq_a: assert property ( // (R7)
        cap_event[1] && mask_ff[2] && $stable(mask_ff)
        |=> status_ff[2] ##1 (irq || !$past(mask_ff[2])))
        else $error("capture event raised no interrupt");

    // (R8) Disabled channel stays quiet.
    ch_quiet_a: assert property ( // (R8)
        pair_sel_ff[5:4] == 2'h0 && $stable(pair_sel_ff)
        |=> !cap_event[2])
        else $error("channel fired with detection off");

    // (R9) Flag sticks until cleared.
    flag_stick_a: assert property ( // (R9)
        status_ff[4] && !clr_bits[4] |=> status_ff[4])
        else $error("capture flag dropped without a clear");

    // (R1) Counter frozen while disabled.
    en_off_a: assert property ( // (R1)
        !ctrl_ff[CTRL_EN_BIT] |=> $stable(count_ff))
        else $error("counter moved while disabled");

    // (R1) Control write lands.
    ctrl_wr_a: assert property ( // (R1)
        wr && paddr == OFS_CTRL |=> ctrl_ff == $past(pwdata[3:0]))
        else $error("control write did not land");

    // (R3) Divide by four pauses.
    div4_tick_a: assert property ( // (R3)
        ctrl_ff[CTRL_SEL_LSB+1:CTRL_SEL_LSB] == SEL_DIV4
        && $stable(ctrl_ff) && tick |=> !tick)
        else $error("divide by four ticked twice in a row");

    // (R6) Last channel latches timebase.
    cap_latch3_a: assert property ( // (R6)
        cap_event[3] |-> cap_value[3] == $past(count_ff))
        else $error("last channel captured a wrong value");

    // (R6) Value holds between captures.
    cap_hold_a: assert property ( // (R6)
        !cap_event[0] |-> $stable(cap_value[0]))
        else $error("captured value changed without an edge");

    // (R7) Unmasked flag raises interrupt.
    irq_set_a: assert property ( // (R7)
        |(status_ff & mask_ff) |=> irq)
        else $error("interrupt missing for an unmasked flag");

    // (R7) No flag, no interrupt.
    irq_clr_a: assert property ( // (R7)
        !(|(status_ff & mask_ff)) |=> !irq)
        else $error("interrupt raised with no unmasked flag");

    // (R8) Second channel quiet when off.
    ch1_quiet_a: assert property ( // (R8)
        pair_sel_ff[3:2] == 2'h0 |=> !cap_event[1])
        else $error("second channel fired with detection off");

    // (R9) Capture event sets flag.
    flag_set_a: assert property ( // (R9)
        cap_event[3] |=> status_ff[ST_CAP_LSB+3])
        else $error("capture event left its flag clear");

    // ************************************************************
    // Cover points.
    // ************************************************************
    ovf_seen_c:   cover property (wrap);
    cap_seen_c:   cover property (cap_event[0] ##1 status_ff[1]);
    match_seen_c: cover property (run && match_clr);
    irq_seen_c:   cover property (!irq ##1 irq);
    both_edge_c:  cover property (cap_event[2] && pair_sel_ff[5:4] == 2'h3);
endmodule // frt_timer
`default_nettype wire

// ### bench/frt_pin_source.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Signal sources that drive the capture pins and the count pin.
// ****************************************************************
module frt_pin_source (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset,
    // Commands from the bench
    input  wire logic [3:0] pin_level,
    input  wire logic       ext_run,
    // Pins
    output logic [3:0]      capture_pin,
    output logic            ext_clk_pin
);
    logic [1:0] phase_ff;

    always_ff @(posedge core_clk) begin
        capture_pin <= pin_level;
    end

    // The count pin stands still unless the bench asks for it, so stray
    // ticks cannot leak into tests of the internal sources.
    always_ff @(posedge core_clk) begin
        if (reset || !ext_run) begin
            phase_ff    <= 2'h0;
            ext_clk_pin <= 1'b0;
        end else if (phase_ff == 2'h2) begin
            phase_ff    <= 2'h0;
            ext_clk_pin <= ~ext_clk_pin;
        end else begin
            phase_ff <= phase_ff + 2'h1;
        end
    end
endmodule // frt_pin_source
`default_nettype wire

// ### bench/frt_timer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module frt_timer_bench;
    import frt_pkg::*;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_clk_pin;
    logic [3:0]  capture_pin;
    logic [3:0]  pin_level = 4'h0;
    logic        ext_run = 1'b0;
    logic [15:0] compare_clear0 = 16'h0000;
    logic [15:0] timebase_value;
    logic        irq;
    int          errors = 0;
    int          tests_run = 0;
    int          cycles = 0;

    always #50 core_clk = ~core_clk;

    frt_timer frt_timer_i (.core_clk(core_clk), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_clk_pin(ext_clk_pin),
        .capture_pin(capture_pin), .compare_clear0(compare_clear0),
        .timebase_value(timebase_value), .irq(irq));

    frt_pin_source frt_pin_source_i (.core_clk(core_clk), .reset(reset),
        .pin_level(pin_level), .ext_run(ext_run),
        .capture_pin(capture_pin), .ext_clk_pin(ext_clk_pin));

    // ****************************************************************
    // Compare, bus and closing tasks.
    // ****************************************************************
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h0000_0000, d, e);
    endtask

    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    task automatic test_reset();
        logic [31:0] d;
        logic        e;
        for (int i = 0; i < 10; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0000_0000, d, e);
            chk_word(d, 32'h0000_0000);
            chk_bit(e, 1'b0);
        end
        wr(OFS_COUNT, 32'h0000_1234);
        rd(OFS_COUNT, d);
        chk_word(d, 32'h0000_0000);
        apb(1'b0, 8'h28, 32'h0000_0000, d, e);
        chk_bit(e, 1'b1);
        chk_word(d, 32'h0000_0000);
        apb(1'b0, 8'h02, 32'h0000_0000, d, e);
        chk_bit(e, 1'b1);
        chk_bit(irq, 1'b0);
        $display("test reset done");
    endtask

    task automatic test_clk_sel();
        logic [15:0] t;
        logic [15:0] exp [4] = '{16'd12, 16'd6, 16'd3, 16'd4};
        for (int s = 0; s < 4; s++) begin
            ext_run <= (s == 3);
            wr(OFS_CTRL, 32'h1 | (s << 1));
            repeat (6) @(posedge core_clk);
            t = timebase_value;
            repeat (24) @(posedge core_clk);
            chk_word({16'h0, 16'(timebase_value - t)}, 32'(exp[s]));
        end
        ext_run <= 1'b0;
        $display("test clock select done");
    endtask

    task automatic test_clear();
        logic [15:0] t;
        logic [15:0] mx;
        logic        seen;
        wr(OFS_CTRL, 32'h0);
        t = timebase_value;
        mx = 16'h0000;
        seen = 1'b0;
        compare_clear0 <= t + 16'd4;
        wr(OFS_CTRL, 32'h9);
        repeat (40) begin
            @(posedge core_clk);
            if (timebase_value > mx) mx = timebase_value;
            if (timebase_value == 16'h0000) seen = 1'b1;
        end
        chk_word({16'h0, mx}, {16'h0, t + 16'd4});
        chk_bit(seen, 1'b1);
        $display("test clear on match done");
    endtask

    // Cases k: edge code, pin goes to ~k[0], hit expected, irq enable k[0].
    task automatic test_capture();
        logic [15:0] codes;
        logic [7:0]  hits;
        logic [7:0]  pa;
        logic [31:0] d;
        logic [15:0] t;
        int          sh;
        codes = 16'h0fa5;
        hits = 8'h39;
        wr(OFS_CTRL, 32'h1);
        for (int ch = 0; ch < 4; ch++) begin
            sh = ch % 2;
            pa = (ch < 2) ? OFS_CAP01 : OFS_CAP23;
            for (int k = 0; k < 8; k++) begin
                wr(pa, (32'(codes[2*k+:2]) << (2 * sh))
                       | ((k % 2) << (PAIR_IE_LSB + sh)));
                wr(OFS_STATUS, 32'h1 << (1 + ch));
                t = timebase_value;
                pin_level[ch] <= ~k[0];
                repeat (10) @(posedge core_clk);
                rd(OFS_STATUS, d);
                chk_bit(d[1+ch], hits[k]);
                rd(pa, d);
                chk_bit(d[PAIR_FL_LSB+sh], hits[k]);
                chk_bit(irq, hits[k] & k[0]);
                rd(OFS_MASK, d);
                chk_bit(d[1+ch], k[0]);
                if (hits[k]) begin
                    rd(OFS_VAL0 + 8'(4 * ch), d);
                    chk_bit(16'(d[15:0] - t) <= 16'd4, 1'b1);
                end
            end
        end
        $display("test capture done");
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            final_report();
        end
    end

    initial begin
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        test_reset();
        test_clk_sel();
        test_clear();
        test_capture();
        final_report();
    end
endmodule // frt_timer_bench
`default_nettype wire
